/* verilog/diag_map.vh */
// constants for the transceiver control, fault and status block
// assumes a two-wire serial host and a 40 MHz system clock
//
// Operation
// [RULE1] transmitter off while disable input high
// [RULE2] undriven disable input reads as high
// [RULE3] host spaces disable assertions 10ms apart
// [RULE4] disable input cycle resets transmitter fault
// [RULE5] serial byte 110 bit 7 asserts disable
// [RULE6] soft bit 6 OR hardware pin disables
// [RULE7] laser fault raises fault, switches laser off
// [RULE8] fault output low normal, high on fault
// [RULE9] fault latched until disable toggle or power
// [RULE10] fault readable at byte 110 bit 2
// [RULE11] unsafe optical output feeds same fault latch
// [RULE12] loss output low adequate, high unusable
// [RULE13] loss state mirrored at byte 110 bit 1
// [RULE14] unused disable input tied to ground
// [RULE15] diagnostic bytes 0-255 at address 0xA2
// [RULE16] synchronise disable, clear on full toggle
`ifndef DIAG_MAP_VH
`define DIAG_MAP_VH

`define DIAG_DEV_ADDR 8'hA2
`define STATUS_CTRL_OFF 8'h6E
`define STAT_HW_DIS_BIT 7
`define STAT_SOFT_DIS_BIT 6
`define STAT_FAULT_BIT 2
`define STAT_LOST_BIT 1
`define DIS_SPACING_MS 10
`define CLK_HZ 40000000

`endif

/* verilog/diag_mem.v */
// 256-byte diagnostic memory with registered read data
// assumes one write port and one read port in the clk domain
module diag_mem (
    input wire clk,
    input wire wr_en,
    input wire [7:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [7:0] rd_addr,
    output reg [7:0] rd_data
);
    reg [7:0] mem [0:255];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* verilog/tx_control_fault_status.v */
// transmitter disable, latched fault and loss-of-signal logic with a
// two-wire serial slave for the diagnostic memory
// assumes scl and sda inputs are synchronous and far slower than clk
`include "diag_map.vh"

module tx_control_fault_status (
    input wire clk,
    input wire srst,
    input wire tx_disable_in,
    input wire laser_fault_in,
    input wire unsafe_output_in,
    input wire signal_absent_flag,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    output reg tx_fault_out,
    output reg tx_fault_oe,
    output reg laser_enable,
    output reg receive_signal_lost
);
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_DEV = 7'h02;
    localparam [6:0] S_ADDR = 7'h04;
    localparam [6:0] S_WR = 7'h08;
    localparam [6:0] S_ACK = 7'h10;
    localparam [6:0] S_RD = 7'h20;
    localparam [6:0] S_RACK = 7'h40;
    localparam [7:0] DEV_ADDR = `DIAG_DEV_ADDR;

    reg dis_meta_reg;
    reg dis_sync_reg;
    reg fault_reg;
    reg fault_next;
    reg seen_high_reg;
    reg seen_high_next;
    reg soft_dis_reg;
    reg serial_dis_reg;
    reg [6:0] state_reg;
    reg [6:0] ret_reg;
    reg [3:0] cnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] ptr_reg;
    reg scl_q_reg;
    reg sda_q_reg;
    reg wr_en_reg;
    reg [7:0] wr_addr_reg;
    reg [7:0] wr_data_reg;
    wire [7:0] mem_q;
    wire fault_event;
    wire disable_any;
    wire start_cond;
    wire stop_cond;
    wire scl_rise;
    wire scl_fall;

    // status/control byte as seen by the host
    function [7:0] status_byte;
        input hw_dis;
        input soft_dis;
        input fault;
        input lost;
        begin
            status_byte = 8'h00;
            status_byte[`STAT_HW_DIS_BIT] = hw_dis;
            status_byte[`STAT_SOFT_DIS_BIT] = soft_dis;
            status_byte[`STAT_FAULT_BIT] = fault;
            status_byte[`STAT_LOST_BIT] = lost;
        end
    endfunction

    diag_mem u_mem (
        .clk(clk),
        .wr_en(wr_en_reg),
        .wr_addr(wr_addr_reg),
        .wr_data(wr_data_reg),
        .rd_addr(ptr_reg),
        .rd_data(mem_q)
    );

    // disable pin synchroniser, reset high so a floating pin disables
    always @(posedge clk) begin
        if (srst) begin
            dis_meta_reg <= 1'b1; // RULE2
            dis_sync_reg <= 1'b1; // RULE16
        end else begin
            dis_meta_reg <= tx_disable_in;
            dis_sync_reg <= dis_meta_reg;
        end
    end

    assign fault_event = laser_fault_in | unsafe_output_in; // RULE11
    assign disable_any = dis_sync_reg | soft_dis_reg | serial_dis_reg; // RULE6

    // fault latch: cleared by a complete high-then-low disable toggle
    always @* begin
        fault_next = fault_reg;
        seen_high_next = seen_high_reg;
        if (fault_reg) begin
            if (dis_sync_reg) begin
                seen_high_next = 1'b1;
            end else if (seen_high_reg) begin
                fault_next = 1'b0; // RULE4
                seen_high_next = 1'b0; // RULE16
            end
        end else begin
            seen_high_next = 1'b0;
        end
        if (fault_event) begin
            fault_next = 1'b1; // RULE9
            seen_high_next = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            fault_reg <= 1'b0;
            seen_high_reg <= 1'b0;
            laser_enable <= 1'b0;
            tx_fault_out <= 1'b0;
            tx_fault_oe <= 1'b1;
            receive_signal_lost <= 1'b0;
        end else begin
            fault_reg <= fault_next;
            seen_high_reg <= seen_high_next;
            laser_enable <= ~(disable_any | fault_next); // RULE1 RULE7
            tx_fault_out <= 1'b0;
            tx_fault_oe <= ~fault_next; // RULE8
            receive_signal_lost <= signal_absent_flag; // RULE12
        end
    end

    assign start_cond = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
    assign stop_cond = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
    assign scl_rise = scl_in & ~scl_q_reg;
    assign scl_fall = ~scl_in & scl_q_reg;

    // two-wire serial slave for the diagnostic memory
    always @(posedge clk) begin
        if (srst) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
            state_reg <= S_IDLE;
            ret_reg <= S_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            wr_en_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            soft_dis_reg <= 1'b0;
            serial_dis_reg <= 1'b0;
        end else begin
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
            sda_out <= 1'b0;
            wr_en_reg <= 1'b0;
            if (start_cond) begin
                state_reg <= S_DEV;
                cnt_reg <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_cond) begin
                state_reg <= S_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state_reg)
                    S_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    S_DEV, S_ADDR, S_WR: begin
                        if (scl_rise && cnt_reg != 4'h8) begin
                            shift_reg <= {shift_reg[6:0], sda_in};
                            cnt_reg <= cnt_reg + 4'h1;
                        end else if (scl_fall && cnt_reg == 4'h8) begin
                            cnt_reg <= 4'h0;
                            state_reg <= S_ACK;
                            sda_oe <= 1'b1;
                            if (state_reg == S_DEV) begin
                                if (shift_reg[7:1] == DEV_ADDR[7:1]) begin
                                    ret_reg <= shift_reg[0] ? S_RD : S_ADDR;
                                end else begin
                                    state_reg <= S_IDLE; // RULE15
                                    sda_oe <= 1'b0;
                                end
                            end else if (state_reg == S_ADDR) begin
                                ptr_reg <= shift_reg;
                                ret_reg <= S_WR;
                            end else begin
                                ret_reg <= S_WR;
                                ptr_reg <= ptr_reg + 8'h01;
                                wr_en_reg <= 1'b1;
                                wr_addr_reg <= ptr_reg;
                                wr_data_reg <= shift_reg;
                                if (ptr_reg == `STATUS_CTRL_OFF) begin
                                    serial_dis_reg <=
                                        shift_reg[`STAT_HW_DIS_BIT]; // RULE5
                                    soft_dis_reg <=
                                        shift_reg[`STAT_SOFT_DIS_BIT];
                                end
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            state_reg <= ret_reg;
                            cnt_reg <= 4'h0;
                            if (ret_reg == S_RD) begin
                                shift_reg <= (ptr_reg == `STATUS_CTRL_OFF) ?
                                    status_byte(dis_sync_reg | serial_dis_reg,
                                        soft_dis_reg, fault_reg, // RULE10
                                        signal_absent_flag) : mem_q; // RULE13
                                sda_oe <= (ptr_reg == `STATUS_CTRL_OFF) ?
                                    ~(dis_sync_reg | serial_dis_reg) :
                                    ~mem_q[7];
                            end else begin
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    S_RD: begin
                        if (scl_fall) begin
                            if (cnt_reg == 4'h7) begin
                                state_reg <= S_RACK;
                                sda_oe <= 1'b0;
                                ptr_reg <= ptr_reg + 8'h01;
                            end else begin
                                cnt_reg <= cnt_reg + 4'h1;
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                sda_oe <= ~shift_reg[6];
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            if (sda_in) begin
                                state_reg <= S_IDLE;
                            end else begin
                                state_reg <= S_ACK;
                                ret_reg <= S_RD;
                            end
                        end
                    end
                    default: begin
                        state_reg <= S_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

/* tb/tx_control_fault_status_props.sv */
// assertions on the control, fault and status ports
// bound to every tx_control_fault_status instance, sees ports only
module tx_props (
    input wire clk,
    input wire srst,
    input wire tx_disable_in,
    input wire laser_fault_in,
    input wire unsafe_output_in,
    input wire signal_absent_flag,
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe,
    input wire tx_fault_out,
    input wire tx_fault_oe,
    input wire laser_enable,
    input wire receive_signal_lost
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_hit;
        laser_fault_in || unsafe_output_in;
    endsequence
    sequence s_lat;
        !tx_fault_oe && !laser_enable;
    endsequence
    chk_fault_sets: assert property (s_hit |=> s_lat)
        else $error("fault event not latched");
    chk_fault_holds: assert property (
        !tx_disable_in [*8] ##0 !tx_fault_oe |=> !tx_fault_oe)
        else $error("fault cleared without toggle");
    chk_laser_off: assert property (
        tx_disable_in [*4] |-> !laser_enable)
        else $error("laser on while pin high");
    chk_laser_gate: assert property (laser_enable |-> tx_fault_oe)
        else $error("laser on during fault");
    chk_lost_follow: assert property (!$past(srst) |->
        receive_signal_lost == $past(signal_absent_flag))
        else $error("loss output does not follow");
    chk_fault_pin: assert property (tx_fault_out == 1'b0)
        else $error("fault pin driven high");
    chk_sda_pin: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    chk_sda_when: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data changed while clock high");
endmodule

bind tx_control_fault_status tx_props chk_u (.clk(clk), .srst(srst),
    .tx_disable_in(tx_disable_in), .laser_fault_in(laser_fault_in),
    .unsafe_output_in(unsafe_output_in), .scl_in(scl_in),
    .signal_absent_flag(signal_absent_flag), .sda_out(sda_out),
    .sda_oe(sda_oe), .tx_fault_out(tx_fault_out), .tx_fault_oe(tx_fault_oe),
    .laser_enable(laser_enable), .receive_signal_lost(receive_signal_lost));

/* tb/host_board.sv */
// host board wiring: pull-ups on open-drain lines, disable pin driver
// assumes the bench plays the serial master behind sda_master
module host_board (
    input wire sda_oe,
    input wire sda_master,
    input wire pin_drive,
    input wire pin_level,
    input wire tx_fault_oe,
    output wire sda_wire,
    output wire pin_wire,
    output wire fault_wire
);
    timeunit 1ns;
    timeprecision 100ps;
    assign sda_wire = sda_oe ? 1'b0 : sda_master;
    // undriven pin floats high through the module pull-up
    assign pin_wire = pin_drive ? pin_level : 1'b1;
    assign fault_wire = tx_fault_oe ? 1'b0 : 1'b1;
endmodule

/* tb/tb_tx_control_fault_status.sv */
// self-checking bench for tx_control_fault_status
// assumes host_board resolves the wires; the bench is the serial master
module tb_tx_control_fault_status;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, srst = 1, pin_drv = 0, pin_val = 1, lf = 0, us = 0;
    logic sab = 0, scl = 1, sdam = 1, a;
    logic [7:0] r, ad, dv;
    logic [7:0] vals [4] = '{8'h40, 8'h80, 8'hC0, 8'h00};
    wire sda_out, sda_oe, flt_out, flt_oe, laser, lost, sdaw, pinw, fltw;
    int errors = 0, n_compared = 0, s7 = 0, s6 = 0, fm = 0, lm = 0;
    tx_control_fault_status dut_u (.clk(clk), .srst(srst),
        .tx_disable_in(pinw), .laser_fault_in(lf), .unsafe_output_in(us),
        .signal_absent_flag(sab), .scl_in(scl), .sda_in(sdaw),
        .sda_out(sda_out), .sda_oe(sda_oe), .tx_fault_out(flt_out),
        .tx_fault_oe(flt_oe), .laser_enable(laser),
        .receive_signal_lost(lost));
    host_board hb_u (.sda_oe(sda_oe), .sda_master(sdam),
        .pin_drive(pin_drv), .pin_level(pin_val), .tx_fault_oe(flt_oe),
        .sda_wire(sdaw), .pin_wire(pinw), .fault_wire(fltw));
    initial forever #12.5 clk = ~clk;
    task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic hp(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic lv(logic c, logic d);
        scl = c;
        sdam = d;
        hp(5);
    endtask
    task automatic st;
        lv(0, 1);
        lv(1, 1);
        lv(1, 0);
    endtask
    task automatic sp;
        lv(0, 0);
        lv(1, 0);
        lv(1, 1);
    endtask
    // eight bits msb first, then the ack slot driven with m
    task automatic xb(logic [7:0] v, logic m);
        for (int i = 7; i >= 0; i--) begin
            lv(0, v[i]);
            lv(1, v[i]);
            r[i] = sdaw;
        end
        lv(0, m);
        lv(1, m);
        a = sdaw;
    endtask
    task automatic wr(logic [7:0] p, logic [7:0] d);
        st;
        xb(8'hA2, 1);
        cmp("ack", 8'h00, {7'h00, a});
        xb(p, 1);
        xb(d, 1);
        sp;
    endtask
    task automatic rd(logic [7:0] p);
        st;
        xb(8'hA2, 1);
        xb(p, 1);
        st;
        xb(8'hA3, 1);
        xb(8'hFF, 1);
        sp;
    endtask
    function automatic logic [7:0] exp_st();
        return {s7[0] | ~pin_drv | pin_val, s6[0], 3'h0, fm[0], lm[0], 1'b0};
    endfunction
    task automatic close_out;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #2000000;
        errors++;
        close_out;
    end
    initial begin
        void'($urandom(78235));
        hp(6);
        srst = 0;
        hp(8);
        cmp("laser", 8'h00, laser);
        cmp("fault", 8'h00, fltw);
        pin_drv = 1;
        pin_val = 0;
        hp(8);
        cmp("laser", 8'h01, laser);
        $display("test pin done");
        foreach (vals[i]) begin
            wr(8'h6E, vals[i]);
            s7 = vals[i][7];
            s6 = vals[i][6];
            lm = $urandom % 2;
            sab = lm[0];
            hp(4);
            cmp("laser", {7'h00, vals[i][7:6] == 2'b00}, laser);
            cmp("lost", 8'(lm), lost);
            rd(8'h6E);
            cmp("status", exp_st(), r);
        end
        $display("test status done");
        ad = 8'($urandom % 100);
        dv = 8'($urandom);
        wr(ad, dv);
        rd(ad);
        cmp("mem", dv, r);
        cmp("data pin", 8'h00, sda_out);
        st;
        xb(8'hA4, 1);
        cmp("nack", 8'h01, {7'h00, a});
        sp;
        $display("test memory done");
        for (int k = 0; k < 2; k++) begin
            lf = (k == 0);
            us = (k == 1);
            hp(1);
            lf = 0;
            us = 0;
            fm = 1;
            hp(20);
            cmp("fault", 8'h01, fltw);
            cmp("fault pin", 8'h00, flt_out);
            rd(8'h6E);
            cmp("status", exp_st(), r);
            // spacing shortened: the latch does not depend on it
            pin_val = 1;
            hp(10);
            pin_val = 0;
            fm = 0;
            hp(10);
            cmp("fault", 8'h00, fltw);
            cmp("laser", 8'h01, laser);
        end
        $display("test fault done");
        close_out;
    end
endmodule
